// File: cta_cfg_bank.sv
// type-c role preference and adaptive input limit configuration bank, apb slave
// assumes paddr is a byte address, one register per aligned word, zero wait states
// Functional notes
// R1 - try-sink enable drives try-sink path and overrides prefer-sink
// R2 - prefer-sink enable favours sink role via try-sink to unattached sink
// R3 - toggle duty code gives 35/40/45/50 percent source share when toggling
// R4 - gating enabled holds limit status while charger detection runs
// R5 - gated sdp with unknown adapter forces limit code by sdp cap
// R6 - writing adaptive enable starts a run unless blocked; bit self-clears
// R7 - block bit refuses and aborts adaptive limiting runs
// R8 - undervoltage level code selects 3.8 v plus 0.1 v per step
// R9 - ceiling code sets stop current in 100 ma steps, top 3.2 a
// R10 - blank time code selects 500 ms, 1 s, 1.5 s or 5 s
// R11 - step time code selects 100, 200, 300 or 500 ms
// R12 - class three registers reset on power-on, fault edge or soft reset
// R13 - fault falling edge resets classes one to three only if select bit set
// R14 - adaptive configuration registers read-only while write protect is set
// R15 - request bits read zero; reserved bits and registers read zero
`timescale 1ns/1ps
module cta_cfg_bank
  import cta_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        config_write_protect,
  input  wire logic        fault_input_pin,
  input  wire logic        bc_detect_running,
  input  wire logic [1:0]  detected_port_type,
  input  wire logic [2:0]  proprietary_adapter_type,
  input  wire logic [6:0]  detected_limit_code,
  input  wire logic        adaptive_input_limiting_done,
  output logic             try_sink_enable,
  output logic             prefer_sink_enable,
  output logic [5:0]       toggle_source_duty_pct,
  output logic [6:0]       input_limit_code,
  output logic             adaptive_input_limiting_start,
  output logic             adaptive_input_limiting_active,
  output logic             adaptive_limit_block,
  output logic [5:0]       uvlo_level_dv,
  output logic [5:0]       adaptive_input_limiting_ceiling_100ma,
  output logic             bypass_undervoltage_debounce,
  output logic [12:0]      blank_time_ms,
  output logic [12:0]      step_time_ms,
  output logic [1:0]       data_switch_control,
  output logic             typec_reset_pulse,
  output logic             low_power_request,
  output logic             low_power_block
);
  logic [7:0]  role_ff, nxt_role, gate_ff, nxt_gate, actl_ff, nxt_actl;
  logic [7:0]  athr_ff, nxt_athr, atim_ff, nxt_atim, dsw_ff, nxt_dsw;
  logic [7:0]  lpow_ff, nxt_lpow, fsel_ff, nxt_fsel;
  logic [6:0]  lim_ff, nxt_lim;
  logic        act_ff, nxt_act, start_ff, nxt_start, srst_ff, nxt_srst;
  logic        lpreq_ff, nxt_lpreq;
  logic [31:0] rdata_ff, nxt_rdata;
  logic        flt_s1_ff, flt_s2_ff, flt_s3_ff;
  logic        fault_rst, setup, wr, mapped;
  logic [7:0]  idx, wb, rsel;

  // pin synchroniser; edge detect looks only at stages two and three
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      flt_s1_ff <= 1'b1;
      flt_s2_ff <= 1'b1;
      flt_s3_ff <= 1'b1;
    end else begin
      flt_s1_ff <= fault_input_pin;
      flt_s2_ff <= flt_s1_ff;
      flt_s3_ff <= flt_s2_ff;
    end
  end

  assign fault_rst = flt_s3_ff & ~flt_s2_ff & fsel_ff[CTA_B_FLTRS]; // see R13
  assign idx       = {2'h0, paddr[7:2]};
  assign setup     = psel & ~penable;
  assign wr        = psel & penable & pwrite & mapped;
  assign wb        = pwdata[7:0];
  assign mapped    = (paddr[1:0] == 2'h0) && (idx >= CTA_IDX_ROLE) && (idx <= CTA_IDX_FSEL);
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~mapped;

  always_comb begin
    unique case (idx)
      CTA_IDX_ROLE:  rsel = role_ff;
      CTA_IDX_LIMST: rsel = {1'b0, lim_ff};
      CTA_IDX_GATE:  rsel = gate_ff;
      CTA_IDX_ACTL:  rsel = actl_ff; // see R15
      CTA_IDX_ATHR:  rsel = athr_ff;
      CTA_IDX_ATIM:  rsel = atim_ff;
      CTA_IDX_DSW:   rsel = dsw_ff;
      CTA_IDX_LPOW:  rsel = lpow_ff;
      CTA_IDX_FSEL:  rsel = fsel_ff;
      default:       rsel = 8'h00; // see R15
    endcase
    nxt_rdata = setup ? {24'h0, rsel} : rdata_ff;
  end

  always_comb begin
    nxt_role  = role_ff;
    nxt_gate  = gate_ff;
    nxt_actl  = actl_ff;
    nxt_athr  = athr_ff;
    nxt_atim  = atim_ff;
    nxt_dsw   = dsw_ff;
    nxt_lpow  = lpow_ff;
    nxt_fsel  = fsel_ff;
    nxt_start = 1'b0;
    nxt_srst  = 1'b0;
    nxt_lpreq = 1'b0;
    if (wr) begin
      unique case (idx)
        CTA_IDX_ROLE: nxt_role = wb & CTA_WM_ROLE;
        CTA_IDX_GATE: nxt_gate = wb & CTA_WM_GATE;
        CTA_IDX_ACTL: begin
          if (!config_write_protect) begin // see R14
            nxt_actl  = {7'h0, wb[CTA_B_BLOCK]};
            nxt_start = wb[CTA_B_REQ] & ~wb[CTA_B_BLOCK]; // see R6
          end
        end
        CTA_IDX_ATHR: if (!config_write_protect) nxt_athr = wb; // see R14
        CTA_IDX_ATIM: if (!config_write_protect) nxt_atim = wb & CTA_WM_ATIM; // see R14
        CTA_IDX_DSW:  nxt_dsw = wb & CTA_WM_DSW;
        CTA_IDX_SRST: nxt_srst = wb[0]; // see R12
        CTA_IDX_LPOW: begin
          nxt_lpow  = {7'h0, wb[CTA_B_BLOCK]};
          nxt_lpreq = wb[CTA_B_REQ] & ~wb[CTA_B_BLOCK];
        end
        CTA_IDX_FSEL: nxt_fsel = wb & CTA_WM_FSEL;
        default: ;
      endcase
    end
    // limit status; detection results pass only when the gate allows
    nxt_lim = lim_ff;
    if (!gate_ff[CTA_B_GATE] || !bc_detect_running) begin // see R4
      nxt_lim = detected_limit_code;
      if (gate_ff[CTA_B_GATE] && detected_port_type == CTA_PORT_SDP &&
          proprietary_adapter_type == CTA_PROP_UNK) begin // see R5
        unique case (gate_ff[2:1])
          2'h1:    nxt_lim = CTA_LIM_500;
          2'h2:    nxt_lim = CTA_LIM_1000;
          2'h3:    nxt_lim = CTA_LIM_1500;
          default: nxt_lim = detected_limit_code;
        endcase
      end
    end
    // run state: the block bit wins over a start or a finishing run
    nxt_act = act_ff;
    if (start_ff) nxt_act = 1'b1;
    if (adaptive_input_limiting_done) nxt_act = 1'b0;
    if (actl_ff[CTA_B_BLOCK]) nxt_act = 1'b0; // see R7
    // soft reset takes class three, fault edge classes one to three
    if (srst_ff || fault_rst) begin // see R12
      nxt_role = CTA_RST_ROLE;
      nxt_gate = CTA_RST_GATE;
      nxt_lim  = CTA_RST_LIMST[6:0];
    end
    if (fault_rst) begin // see R13
      nxt_actl  = CTA_RST_ACTL;
      nxt_athr  = CTA_RST_ATHR;
      nxt_atim  = CTA_RST_ATIM;
      nxt_dsw   = CTA_RST_DSW;
      nxt_lpow  = CTA_RST_LPOW;
      nxt_act   = 1'b0;
      nxt_start = 1'b0;
      nxt_lpreq = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      role_ff  <= CTA_RST_ROLE;
      gate_ff  <= CTA_RST_GATE;
      actl_ff  <= CTA_RST_ACTL;
      athr_ff  <= CTA_RST_ATHR;
      atim_ff  <= CTA_RST_ATIM;
      dsw_ff   <= CTA_RST_DSW;
      lpow_ff  <= CTA_RST_LPOW;
      fsel_ff  <= CTA_RST_FSEL;
      lim_ff   <= CTA_RST_LIMST[6:0];
      act_ff   <= 1'b0;
      start_ff <= 1'b0;
      srst_ff  <= 1'b0;
      lpreq_ff <= 1'b0;
      rdata_ff <= 32'h0;
    end else begin
      role_ff  <= nxt_role;
      gate_ff  <= nxt_gate;
      actl_ff  <= nxt_actl;
      athr_ff  <= nxt_athr;
      atim_ff  <= nxt_atim;
      dsw_ff   <= nxt_dsw;
      lpow_ff  <= nxt_lpow;
      fsel_ff  <= nxt_fsel;
      lim_ff   <= nxt_lim;
      act_ff   <= nxt_act;
      start_ff <= nxt_start;
      srst_ff  <= nxt_srst;
      lpreq_ff <= nxt_lpreq;
      rdata_ff <= nxt_rdata;
    end
  end

  assign prdata                       = rdata_ff;
  assign try_sink_enable              = role_ff[CTA_B_TRY]; // see R1
  assign prefer_sink_enable           = role_ff[CTA_B_PREF] & ~role_ff[CTA_B_TRY]; // see R1, R2
  assign toggle_source_duty_pct       = CTA_DUTY_BASE + 6'(role_ff[1:0] * CTA_DUTY_STEP); // see R3
  assign input_limit_code             = lim_ff;
  assign adaptive_input_limiting_start                   = start_ff; // see R6
  assign adaptive_input_limiting_active                  = act_ff;
  assign adaptive_limit_block         = actl_ff[CTA_B_BLOCK]; // see R7
  assign uvlo_level_dv                = CTA_UV_BASE + {3'h0, athr_ff[7:5]}; // see R8
  assign adaptive_input_limiting_ceiling_100ma           = {1'b0, athr_ff[4:0]} + 6'h01; // see R9
  assign bypass_undervoltage_debounce = atim_ff[6];
  assign blank_time_ms = cta_pick_ms(atim_ff[3:2], CTA_BLK_MS0, CTA_BLK_MS1,
                                     CTA_BLK_MS2, CTA_BLK_MS3); // see R10
  assign step_time_ms  = cta_pick_ms(atim_ff[1:0], CTA_STP_MS0, CTA_STP_MS1,
                                     CTA_STP_MS2, CTA_STP_MS3); // see R11
  assign data_switch_control          = dsw_ff[1:0];
  assign typec_reset_pulse            = srst_ff;
  assign low_power_request            = lpreq_ff;
  assign low_power_block              = lpow_ff[CTA_B_BLOCK];

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_try_wins;
    role_ff[CTA_B_TRY] |-> !prefer_sink_enable && try_sink_enable;
  endproperty
  a_try_wins: assert property (p_try_wins) else $error("prefer active with try"); // see R1

  property p_duty;
    role_ff[1:0] == 2'h3 |-> toggle_source_duty_pct == 6'd50;
  endproperty
  a_duty: assert property (p_duty) else $error("duty share wrong"); // see R3

  property p_gate_hold;
    gate_ff[CTA_B_GATE] && bc_detect_running && !srst_ff && !fault_rst
      |=> $stable(input_limit_code);
  endproperty
  a_gate_hold: assert property (p_gate_hold) else $error("limit moved while gated"); // see R4

  property p_sdp_force;
    gate_ff[CTA_B_GATE] && gate_ff[2:1] == 2'h2 && !bc_detect_running && !srst_ff &&
      !fault_rst && detected_port_type == CTA_PORT_SDP && proprietary_adapter_type == 3'h0
      |=> input_limit_code == 7'h1e;
  endproperty
  a_sdp_force: assert property (p_sdp_force) else $error("sdp cap not forced"); // see R5

  property p_start;
    wr && idx == CTA_IDX_ACTL && wb[7] && !wb[0] && !config_write_protect && !fault_rst
      |=> adaptive_input_limiting_start ##1 !adaptive_input_limiting_start && (adaptive_input_limiting_active || adaptive_limit_block || $past(adaptive_input_limiting_done));
  endproperty
  a_start: assert property (p_start) else $error("adaptive start missing"); // see R6

  // a write that sets the block during a run drops the run state one cycle later, so the
  // check starts only once the block has stood for a full cycle
  property p_block;
    adaptive_limit_block && $past(adaptive_limit_block) |-> !adaptive_input_limiting_active && !adaptive_input_limiting_start;
  endproperty
  a_block: assert property (p_block) else $error("run while blocked"); // see R7

  property p_soft_rst;
    typec_reset_pulse |=> role_ff == CTA_RST_ROLE && gate_ff == CTA_RST_GATE;
  endproperty
  a_soft_rst: assert property (p_soft_rst) else $error("soft reset missed"); // see R12

  property p_fault;
    fault_rst |=> athr_ff == CTA_RST_ATHR && dsw_ff == CTA_RST_DSW && fsel_ff == $past(fsel_ff);
  endproperty
  a_fault: assert property (p_fault) else $error("fault reset wrong"); // see R13

  property p_protect;
    wr && config_write_protect && idx == CTA_IDX_ATHR && !fault_rst |=> $stable(athr_ff);
  endproperty
  a_protect: assert property (p_protect) else $error("protected write landed"); // see R14

  property p_rsvd;
    setup && (idx == CTA_IDX_RSVA || idx == CTA_IDX_SRST) |=> prdata == 32'h0;
  endproperty
  a_rsvd: assert property (p_rsvd) else $error("reserved read nonzero"); // see R15

  property p_lim_follow;
    !gate_ff[CTA_B_GATE] && !srst_ff && !fault_rst
      |=> input_limit_code == $past(detected_limit_code);
  endproperty
  a_lim_follow: assert property (p_lim_follow) else $error("ungated limit stuck"); // see R4

  property p_sdp_500;
    gate_ff[CTA_B_GATE] && gate_ff[2:1] == 2'h1 && !bc_detect_running && !srst_ff &&
      !fault_rst && detected_port_type == 2'h1 && proprietary_adapter_type == 3'h0
      |=> input_limit_code == 7'h0f;
  endproperty
  a_sdp_500: assert property (p_sdp_500) else $error("sdp 500 not forced"); // see R5

  property p_sdp_1500;
    gate_ff[CTA_B_GATE] && gate_ff[2:1] == 2'h3 && !bc_detect_running && !srst_ff &&
      !fault_rst && detected_port_type == 2'h1 && proprietary_adapter_type == 3'h0
      |=> input_limit_code == 7'h2d;
  endproperty
  a_sdp_1500: assert property (p_sdp_1500) else $error("sdp 1500 not forced"); // see R5

  property p_sdp_none;
    gate_ff[CTA_B_GATE] && gate_ff[2:1] == 2'h0 && !bc_detect_running && !srst_ff &&
      !fault_rst |=> input_limit_code == $past(detected_limit_code);
  endproperty
  a_sdp_none: assert property (p_sdp_none) else $error("cap 00 changed limit"); // see R5

  property p_start_once;
    adaptive_input_limiting_start |=> !adaptive_input_limiting_start;
  endproperty
  a_start_once: assert property (p_start_once) else $error("start not a pulse"); // see R6

  property p_act_rise;
    adaptive_input_limiting_start && !adaptive_limit_block && !adaptive_input_limiting_done && !fault_rst |=> adaptive_input_limiting_active;
  endproperty
  a_act_rise: assert property (p_act_rise) else $error("run did not begin"); // see R6

  property p_done;
    adaptive_input_limiting_done |=> !adaptive_input_limiting_active;
  endproperty
  a_done: assert property (p_done) else $error("run outlived done"); // see R6

  property p_refuse;
    wr && idx == CTA_IDX_ACTL && wb[0] |=> !adaptive_input_limiting_start;
  endproperty
  a_refuse: assert property (p_refuse) else $error("blocked start issued"); // see R7

  property p_uv_top;
    athr_ff[7:5] == 3'h7 |-> uvlo_level_dv == 6'd45;
  endproperty
  a_uv_top: assert property (p_uv_top) else $error("top undervoltage level wrong"); // see R8

  property p_ceil_top;
    athr_ff[4:0] == 5'h1f |-> adaptive_input_limiting_ceiling_100ma == 6'd32;
  endproperty
  a_ceil_top: assert property (p_ceil_top) else $error("top ceiling wrong"); // see R9

  property p_blk_max;
    atim_ff[3:2] == 2'h3 |-> blank_time_ms == 13'd5000;
  endproperty
  a_blk_max: assert property (p_blk_max) else $error("longest blank wrong"); // see R10

  property p_stp_min;
    atim_ff[1:0] == 2'h0 |-> step_time_ms == 13'd100;
  endproperty
  a_stp_min: assert property (p_stp_min) else $error("shortest step wrong"); // see R11

  property p_lim_srst;
    typec_reset_pulse |=> input_limit_code == 7'h00;
  endproperty
  a_lim_srst: assert property (p_lim_srst) else $error("limit kept over soft reset"); // see R12

  property p_flt_off;
    flt_s3_ff && !flt_s2_ff && !fsel_ff[CTA_B_FLTRS] && !wr |=> $stable(athr_ff);
  endproperty
  a_flt_off: assert property (p_flt_off) else $error("disabled fault edge reset"); // see R13

  property p_protect_tim;
    wr && config_write_protect && idx == CTA_IDX_ATIM && !fault_rst |=> $stable(atim_ff);
  endproperty
  a_protect_tim: assert property (p_protect_tim) else $error("protected timing write"); // see R14

  property p_srst_clr;
    typec_reset_pulse |=> !typec_reset_pulse;
  endproperty
  a_srst_clr: assert property (p_srst_clr) else $error("soft reset not a pulse"); // see R15

  // main scenarios worth seeing at least once

  c_start: cover property (adaptive_input_limiting_start ##[1:5] adaptive_input_limiting_active);
  c_force: cover property (gate_ff[CTA_B_GATE] && input_limit_code == CTA_LIM_500);
  c_fault: cover property (fault_rst);
  c_err:   cover property (pslverr);
endmodule : cta_cfg_bank

// File: cta_pkg.sv
// constants for the type-c / adaptive limit configuration register bank
// assumes a byte-wide register map reached as one apb word per register
package cta_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] CTA_IDX_ROLE   = 8'h29;
  localparam logic [7:0] CTA_IDX_LIMST  = 8'h2a;
  localparam logic [7:0] CTA_IDX_GATE   = 8'h2b;
  localparam logic [7:0] CTA_IDX_ACTL   = 8'h2c;
  localparam logic [7:0] CTA_IDX_ATHR   = 8'h2d;
  localparam logic [7:0] CTA_IDX_ATIM   = 8'h2e;
  localparam logic [7:0] CTA_IDX_DSW    = 8'h2f;
  localparam logic [7:0] CTA_IDX_SRST   = 8'h30;
  localparam logic [7:0] CTA_IDX_RSVA   = 8'h31;
  localparam logic [7:0] CTA_IDX_RSVB   = 8'h32;
  localparam logic [7:0] CTA_IDX_LPOW   = 8'h33;
  localparam logic [7:0] CTA_IDX_RSVC   = 8'h34;
  localparam logic [7:0] CTA_IDX_FSEL   = 8'h35;
  // values after reset
  localparam logic [7:0] CTA_RST_ROLE   = 8'h08;
  localparam logic [7:0] CTA_RST_LIMST  = 8'h00;
  localparam logic [7:0] CTA_RST_GATE   = 8'h0b;
  localparam logic [7:0] CTA_RST_ACTL   = 8'h01;
  localparam logic [7:0] CTA_RST_ATHR   = 8'h44;
  localparam logic [7:0] CTA_RST_ATIM   = 8'h05;
  localparam logic [7:0] CTA_RST_DSW    = 8'h01;
  localparam logic [7:0] CTA_RST_LPOW   = 8'h01;
  localparam logic [7:0] CTA_RST_FSEL   = 8'h80;
  // writable bits
  localparam logic [7:0] CTA_WM_ROLE    = 8'h0f;
  localparam logic [7:0] CTA_WM_GATE    = 8'h0f;
  localparam logic [7:0] CTA_WM_ATIM    = 8'h4f;
  localparam logic [7:0] CTA_WM_DSW     = 8'h03;
  localparam logic [7:0] CTA_WM_FSEL    = 8'hc0;
  // field positions
  localparam int CTA_B_TRY   = 3;
  localparam int CTA_B_PREF  = 2;
  localparam int CTA_B_GATE  = 3;
  localparam int CTA_B_REQ   = 7;
  localparam int CTA_B_BLOCK = 0;
  localparam int CTA_B_FLTRS = 7;
  // forced limit codes and port types
  localparam logic [6:0] CTA_LIM_500  = 7'h0f;
  localparam logic [6:0] CTA_LIM_1000 = 7'h1e;
  localparam logic [6:0] CTA_LIM_1500 = 7'h2d;
  localparam logic [1:0] CTA_PORT_SDP = 2'h1;
  localparam logic [2:0] CTA_PROP_UNK = 3'h0;
  // source share of a toggle period, percent
  localparam logic [5:0] CTA_DUTY_BASE = 6'h23;
  localparam logic [5:0] CTA_DUTY_STEP = 6'h05;
  // undervoltage level in 0.1 v units, ceiling in 100 ma units
  localparam logic [5:0] CTA_UV_BASE   = 6'h26;
  // interval figures in ms
  localparam logic [12:0] CTA_BLK_MS0 = 13'd500;
  localparam logic [12:0] CTA_BLK_MS1 = 13'd1000;
  localparam logic [12:0] CTA_BLK_MS2 = 13'd1500;
  localparam logic [12:0] CTA_BLK_MS3 = 13'd5000;
  localparam logic [12:0] CTA_STP_MS0 = 13'd100;
  localparam logic [12:0] CTA_STP_MS1 = 13'd200;
  localparam logic [12:0] CTA_STP_MS2 = 13'd300;
  localparam logic [12:0] CTA_STP_MS3 = 13'd500;

  function automatic logic [12:0] cta_pick_ms(input logic [1:0] c, input logic [12:0] a,
      input logic [12:0] b, input logic [12:0] d, input logic [12:0] e);
    unique case (c)
      2'h0: cta_pick_ms = a;
      2'h1: cta_pick_ms = b;
      2'h2: cta_pick_ms = d;
      2'h3: cta_pick_ms = e;
    endcase
  endfunction : cta_pick_ms
endpackage : cta_pkg

// File: cta_host_model.sv
// apb master standing in for host software; the bench calls its task
// assumes one clock and a slave that may add wait states
`timescale 1ns/1ps
module cta_host_model (
  input  wire logic        pclk,
  input  wire logic        pready,
  input  wire logic        pslverr,
  input  wire logic [31:0] prdata,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata
);
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
  end
  task automatic xfer(input logic wr, input logic [7:0] ad, input logic [7:0] wd,
                      output logic [7:0] rd, output logic err);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= ad;
    pwdata  <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    // idle bus shows the inverse, so a slave still sampling it is caught
    paddr   <= ~ad;
    pwdata  <= ~pwdata;
  endtask : xfer
endmodule : cta_host_model

// File: charger_typec_adaptive_input_limiting_config_bank_tb.sv
// self-checking bench for the configuration bank
// assumes cta_host_model as bus master and the package constants
`timescale 1ns/1ps
module charger_typec_adaptive_input_limiting_config_bank_tb;
  import cta_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, prot = 1'b0, fpin = 1'b1, bcrun = 1'b1;
  logic        adone = 1'b0, psel, penable, pwrite, pready, pslverr;
  logic        try_o, pref_o, st_o, act_o, blk_o, deb_o, trst_o, lpr_o, lpb_o;
  logic [1:0]  ptype = CTA_PORT_SDP, dsw_o;
  logic [2:0]  prop = CTA_PROP_UNK;
  logic [6:0]  dlim = 7'h55, lim_o;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic [5:0]  duty_o, uv_o, ceil_o;
  logic [12:0] blk_ms, stp_ms;
  int          miscompares = 0, num_checks = 0, cyc = 0, n_st = 0, n_tr = 0, n_lp = 0;
  logic [7:0]  rst_tab [13] = '{8'h08, 8'h00, 8'h0b, 8'h01, 8'h44, 8'h05, 8'h01, 8'h00,
                                8'h00, 8'h00, 8'h01, 8'h00, 8'h80};
  logic [12:0] blk_tab [4] = '{13'd500, 13'd1000, 13'd1500, 13'd5000};
  logic [12:0] stp_tab [4] = '{13'd100, 13'd200, 13'd300, 13'd500};
  logic [6:0]  cap_tab [4] = '{7'h55, 7'h0f, 7'h1e, 7'h2d};

  always #2.5 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    n_st <= n_st + st_o;
    n_tr <= n_tr + trst_o;
    n_lp <= n_lp + lpr_o;
    if (cyc == 20000) begin
      miscompares++;
      end_of_test();
    end
  end

  cta_host_model host_u (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  cta_cfg_bank dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .config_write_protect(prot), .fault_input_pin(fpin),
    .bc_detect_running(bcrun), .detected_port_type(ptype), .proprietary_adapter_type(prop),
    .detected_limit_code(dlim), .adaptive_input_limiting_done(adone), .try_sink_enable(try_o),
    .prefer_sink_enable(pref_o), .toggle_source_duty_pct(duty_o), .input_limit_code(lim_o),
    .adaptive_input_limiting_start(st_o), .adaptive_input_limiting_active(act_o), .adaptive_limit_block(blk_o),
    .uvlo_level_dv(uv_o), .adaptive_input_limiting_ceiling_100ma(ceil_o), .bypass_undervoltage_debounce(deb_o),
    .blank_time_ms(blk_ms), .step_time_ms(stp_ms), .data_switch_control(dsw_o),
    .typec_reset_pulse(trst_o), .low_power_request(lpr_o), .low_power_block(lpb_o));

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [7:0] r;
    logic       e;
    host_u.xfer(1'b1, {idx[5:0], 2'b00}, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
    logic [7:0] r;
    logic       e;
    host_u.xfer(1'b0, {idx[5:0], 2'b00}, 8'h00, r, e);
    chk(r, exp);
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(posedge pclk);
    #1;
  endtask : idle

  task automatic t_reset_map();
    logic [7:0] r;
    logic       e;
    for (int i = 0; i < 13; i++) rd(CTA_IDX_ROLE + i[7:0], rst_tab[i]);
    wr(CTA_IDX_RSVA, 8'hff);
    rd(CTA_IDX_RSVA, 8'h00);
    host_u.xfer(1'b1, 8'hd8, 8'h00, r, e);
    chk(e, 1'b1);
    host_u.xfer(1'b0, 8'ha5, 8'h00, r, e);
    chk(e, 1'b1);
    $display("done: reset map");
  endtask : t_reset_map

  task automatic t_role();
    for (int c = 0; c < 4; c++) begin
      wr(CTA_IDX_ROLE, (c[0] ? 8'h0c : 8'h04) | c[7:0]);
      idle(1);
      chk(try_o, c[0]);
      chk(pref_o, !c[0]);
      chk(duty_o, 6'd35 + 6'd5 * c[5:0]);
    end
    $display("done: role");
  endtask : t_role

  task automatic t_limit();
    idle(3);
    chk(lim_o, 7'h00);
    bcrun <= 1'b0;
    for (int c = 0; c < 4; c++) begin
      wr(CTA_IDX_GATE, 8'h08 | (c[7:0] << 1));
      idle(3);
      chk(lim_o, cap_tab[c]);
    end
    dlim <= 7'h22;
    bcrun <= 1'b1;
    wr(CTA_IDX_GATE, 8'h02);
    idle(3);
    chk(lim_o, 7'h22);
    rd(CTA_IDX_LIMST, 8'h22);
    $display("done: limit");
  endtask : t_limit

  task automatic t_adaptive_input_limiting();
    wr(CTA_IDX_ACTL, 8'h81);
    idle(3);
    chk(n_st, 0);
    wr(CTA_IDX_ACTL, 8'h80);
    idle(3);
    chk({n_st[3:0], act_o}, 5'h03);
    rd(CTA_IDX_ACTL, 8'h00);
    wr(CTA_IDX_ACTL, 8'h01);
    idle(2);
    chk({blk_o, act_o}, 2'b10);
    wr(CTA_IDX_ACTL, 8'h80);
    idle(3);
    adone <= 1'b1;
    idle(2);
    adone <= 1'b0;
    chk({n_st[3:0], act_o}, 5'h04);
    prot <= 1'b1;
    wr(CTA_IDX_ACTL, 8'h01);
    wr(CTA_IDX_ATHR, 8'h00);
    rd(CTA_IDX_ACTL, 8'h00);
    rd(CTA_IDX_ATHR, 8'h44);
    prot <= 1'b0;
    $display("done: adaptive run");
  endtask : t_adaptive_input_limiting

  task automatic t_timing();
    for (int i = 0; i < 8; i++) begin
      wr(CTA_IDX_ATHR, {i[2:0], i[2:0], 2'b11});
      idle(1);
      chk(uv_o, 6'd38 + i[5:0]);
      chk(ceil_o, {1'b0, i[2:0], 2'b11} + 6'd1);
    end
    for (int c = 0; c < 4; c++) begin
      wr(CTA_IDX_ATIM, {1'b0, c[0], 2'b00, 2'(c), 2'(3 - c)});
      idle(1);
      chk({deb_o, blk_ms, stp_ms}, {c[0], blk_tab[c], stp_tab[3 - c]});
    end
    $display("done: timing fields");
  endtask : t_timing

  task automatic t_resets();
    wr(CTA_IDX_ROLE, 8'h00);
    wr(CTA_IDX_LPOW, 8'h80);
    wr(CTA_IDX_SRST, 8'h01);
    idle(2);
    chk({n_tr[3:0], n_lp[3:0]}, 8'h11);
    rd(CTA_IDX_ROLE, 8'h08);
    rd(CTA_IDX_SRST, 8'h00);
    rd(CTA_IDX_ATIM, 8'h4c);
    fpin <= 1'b0;
    idle(8);
    rd(CTA_IDX_ATHR, 8'h44);
    rd(CTA_IDX_FSEL, 8'h80);
    wr(CTA_IDX_FSEL, 8'h00);
    fpin <= 1'b1;
    wr(CTA_IDX_ATHR, 8'h1f);
    fpin <= 1'b0;
    idle(8);
    rd(CTA_IDX_ATHR, 8'h1f);
    $display("done: reset classes");
  endtask : t_resets

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_role();
    t_limit();
    t_adaptive_input_limiting();
    t_timing();
    t_resets();
    end_of_test();
  end
endmodule : charger_typec_adaptive_input_limiting_config_bank_tb
